// >>> rtl/acc_analog_comparator_control.sv
// Operation
// - bandgap select bit six puts bandgap on positive input, else positive pin
// - mux enable with converter off routes channel to negative input, else pin
// - raw comparator result high when positive input exceeds negative input
// - result passes a two flop synchroniser, one to two cycles latency
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - hardware sets flag bit four on the selected synchronised event
// - flag clears on vector entry or software write of one
// - interrupt request needs flag, enable bit three and global enable
// - disable bit seven powers comparator off, writable any time
// - capture enable bit two routes result to timer capture, else none
// - comparator capture interrupt only with timer capture irq enable set
// - converter mux usable as negative source only with power reduce clear
// - buffer off bits one and zero disable pin buffers, force pin reads zero
// - unused bits seven to two of pin disable register read zero
`timescale 1ns/10ps
module acc_analog_comparator_control
    import acc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog front end
    input wire logic compare_raw,
    output acc_analog_ctrl_s analog_ctrl,
    // pin buffers and port reads
    input wire logic positive_pin_digital,
    input wire logic negative_pin_digital,
    output logic pos_pin_buffer_off,
    output logic neg_pin_buffer_off,
    output logic positive_pin_read,
    output logic negative_pin_read,
    // system inputs
    input wire logic global_irq_enable,
    input wire logic vector_ack,
    input wire logic converter_power_reduce,
    input wire logic timer_capture_irq_enable,
    // outputs to cpu and timer
    output logic compare_irq_req,
    output logic capture_source,
    output logic capture_route_enable,
    output logic capture_irq_allowed,
    output logic event_irq
);

    acc_bus_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [7:0] ctrl_q, ctrl_d;
    logic flag_q, flag_d;
    logic [7:0] conv_b_q;
    logic [1:0] pin_dis_q;
    logic [7:0] conv_a_q;
    logic [7:0] mux_sel_q;
    logic [1:0] ev_stat_q, ev_stat_d;
    logic [1:0] ev_mask_q;
    logic [1:0] sync_q;
    logic prev_q;
    logic [1:0] pin_sync1_q, pin_sync2_q;

    wire sel_ctrl = (req.addr == ACC_CTRL_STATUS_OFF);
    wire sel_conv_b = (req.addr == ACC_CONV_CTRL_B_OFF);
    wire sel_pin = (req.addr == ACC_PIN_DISABLE_OFF);
    wire sel_stat = (req.addr == ACC_IRQ_STATUS_OFF);
    wire sel_mask = (req.addr == ACC_IRQ_MASK_OFF);
    wire sel_conv_a = (req.addr == ACC_CONV_CTRL_A_OFF);
    wire sel_mux = (req.addr == ACC_MUX_SELECT_OFF);

    // synchronised comparator result
    wire result_sync = sync_q[1];
    wire rise = result_sync & ~prev_q;
    wire fall = ~result_sync & prev_q;
    wire [1:0] mode = ctrl_q[ACC_MODE_HI_BIT:ACC_MODE_LO_BIT];

    logic mode_event;
    always_comb begin
        case (acc_mode_e'(mode))
            ACC_MODE_TOGGLE: mode_event = rise | fall;
            ACC_MODE_FALL: mode_event = fall;
            ACC_MODE_RISE: mode_event = rise;
            default: mode_event = 1'b0;
        endcase
    end

    // set wins over both clears
    wire flag_wr_clr = req.wr & sel_ctrl & req.wdata[ACC_FLAG_BIT];
    always_comb begin
        flag_d = flag_q;
        if (vector_ack | flag_wr_clr) begin
            flag_d = 1'b0;
        end
        if (mode_event) begin
            flag_d = 1'b1;
        end
    end

    // control register: result and flag bits are not stored here
    always_comb begin
        ctrl_d = ctrl_q;
        if (req.wr & sel_ctrl) begin
            ctrl_d = req.wdata;
            ctrl_d[ACC_RESULT_BIT] = 1'b0;
            ctrl_d[ACC_FLAG_BIT] = 1'b0;
        end
    end

    // sticky block events: the mode-selected edge, and any result change
    wire [1:0] ev_now;
    assign ev_now[ACC_EV_EDGE_BIT] = mode_event;
    assign ev_now[ACC_EV_CHANGE_BIT] = rise | fall;
    wire stat_rd_clr = req.rd & sel_stat;
    always_comb begin
        ev_stat_d = ev_stat_q;
        if (stat_rd_clr) begin
            ev_stat_d = 2'b00;
        end
        ev_stat_d = ev_stat_d | ev_now;
    end

    // analog routing
    wire mux_usable = ~converter_power_reduce;
    wire neg_mux = conv_b_q[ACC_NEG_MUX_EN_BIT] & ~conv_a_q[ACC_CONV_EN_BIT]
                   & mux_usable;
    acc_analog_ctrl_s analog_d;
    assign analog_d.power_off = ctrl_q[ACC_POWER_OFF_BIT];
    assign analog_d.bandgap_sel = ctrl_q[ACC_BANDGAP_BIT];
    assign analog_d.neg_from_mux = neg_mux;
    assign analog_d.channel = mux_sel_q[ACC_CHAN_LSB +: ACC_CHAN_W];

    // read mux
    wire [7:0] ctrl_view = {ctrl_q[7:6], result_sync, flag_q, ctrl_q[3:0]};
    wire [7:0] rd_mux =
        sel_ctrl ? ctrl_view :
        sel_conv_b ? conv_b_q :
        sel_pin ? {6'h00, pin_dis_q} :
        sel_stat ? {6'h00, ev_stat_q} :
        sel_mask ? {6'h00, ev_mask_q} :
        sel_conv_a ? conv_a_q :
        sel_mux ? mux_sel_q : ACC_UNMAPPED_READ;

    wire capture_on = ctrl_q[ACC_CAPTURE_BIT];
    wire irq_d = flag_d & ctrl_d[ACC_IRQ_EN_BIT] & global_irq_enable;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_q <= 2'b00;
            prev_q <= 1'b0;
            pin_sync1_q <= 2'b00;
            pin_sync2_q <= 2'b00;
        end else begin
            sync_q <= {sync_q[0], compare_raw};
            prev_q <= sync_q[1];
            pin_sync1_q <= {negative_pin_digital, positive_pin_digital};
            pin_sync2_q <= pin_sync1_q;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= ACC_REG_RESET;
            flag_q <= 1'b0;
            ev_stat_q <= 2'b00;
        end else begin
            ctrl_q <= ctrl_d;
            flag_q <= flag_d;
            ev_stat_q <= ev_stat_d;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_b_q <= ACC_REG_RESET;
            pin_dis_q <= 2'b00;
            ev_mask_q <= 2'b00;
            conv_a_q <= ACC_REG_RESET;
            mux_sel_q <= ACC_REG_RESET;
        end else if (req.wr) begin
            if (sel_conv_b) begin
                conv_b_q <= req.wdata;
            end else if (sel_pin) begin
                pin_dis_q <= req.wdata[1:0];
            end else if (sel_mask) begin
                ev_mask_q <= req.wdata[1:0];
            end else if (sel_conv_a) begin
                conv_a_q <= req.wdata;
            end else if (sel_mux) begin
                mux_sel_q <= req.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            analog_ctrl <= '0;
            pos_pin_buffer_off <= 1'b0;
            neg_pin_buffer_off <= 1'b0;
            positive_pin_read <= 1'b0;
            negative_pin_read <= 1'b0;
            compare_irq_req <= 1'b0;
            capture_source <= 1'b0;
            capture_route_enable <= 1'b0;
            capture_irq_allowed <= 1'b0;
            event_irq <= 1'b0;
        end else begin
            reg_rdata <= req.rd ? rd_mux : 8'h00;
            analog_ctrl <= analog_d;
            pos_pin_buffer_off <= pin_dis_q[ACC_POS_BUF_OFF_BIT];
            neg_pin_buffer_off <= pin_dis_q[ACC_NEG_BUF_OFF_BIT];
            positive_pin_read <= pin_sync2_q[0] & ~pin_dis_q[ACC_POS_BUF_OFF_BIT];
            negative_pin_read <= pin_sync2_q[1] & ~pin_dis_q[ACC_NEG_BUF_OFF_BIT];
            compare_irq_req <= irq_d;
            capture_source <= capture_on & result_sync;
            capture_route_enable <= capture_on;
            capture_irq_allowed <= capture_on & timer_capture_irq_enable;
            event_irq <= |(ev_stat_d & ev_mask_q);
        end
    end

endmodule

// >>> rtl/acc_pkg.sv
package acc_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] ACC_CTRL_STATUS_OFF = 8'h50;
    localparam logic [7:0] ACC_CONV_CTRL_B_OFF = 8'h51;
    localparam logic [7:0] ACC_PIN_DISABLE_OFF = 8'h52;
    localparam logic [7:0] ACC_IRQ_STATUS_OFF = 8'h53;
    localparam logic [7:0] ACC_IRQ_MASK_OFF = 8'h54;
    localparam logic [7:0] ACC_CONV_CTRL_A_OFF = 8'h55;
    localparam logic [7:0] ACC_MUX_SELECT_OFF = 8'h56;

    // control/status field positions
    localparam int ACC_POWER_OFF_BIT = 7;
    localparam int ACC_BANDGAP_BIT = 6;
    localparam int ACC_RESULT_BIT = 5;
    localparam int ACC_FLAG_BIT = 4;
    localparam int ACC_IRQ_EN_BIT = 3;
    localparam int ACC_CAPTURE_BIT = 2;
    localparam int ACC_MODE_HI_BIT = 1;
    localparam int ACC_MODE_LO_BIT = 0;
    // converter control b
    localparam int ACC_NEG_MUX_EN_BIT = 6;
    // pin disable register
    localparam int ACC_NEG_BUF_OFF_BIT = 1;
    localparam int ACC_POS_BUF_OFF_BIT = 0;
    // converter control a / mux select
    localparam int ACC_CONV_EN_BIT = 7;
    localparam int ACC_CHAN_LSB = 0;
    localparam int ACC_CHAN_W = 3;
    // event status / mask bits
    localparam int ACC_EV_EDGE_BIT = 0;
    localparam int ACC_EV_CHANGE_BIT = 1;

    localparam logic [7:0] ACC_REG_RESET = 8'h00;
    localparam logic [7:0] ACC_UNMAPPED_READ = 8'h00;

    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE = 2'b00,
        ACC_MODE_RESERVED = 2'b01,
        ACC_MODE_FALL = 2'b10,
        ACC_MODE_RISE = 2'b11
    } acc_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acc_bus_req_s;

    typedef struct packed {
        logic power_off;
        logic bandgap_sel;
        logic neg_from_mux;
        logic [ACC_CHAN_W-1:0] channel;
    } acc_analog_ctrl_s;
endpackage

// >>> verification/acc_monitor.sv
`timescale 1ns/10ps
module acc_monitor
    import acc_pkg::*;
(
    // clock, reset, bus
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // watched signals
    input wire acc_analog_ctrl_s analog_ctrl,
    input wire logic converter_power_reduce,
    input wire logic global_irq_enable,
    input wire logic timer_capture_irq_enable,
    input wire logic pos_pin_buffer_off,
    input wire logic positive_pin_read,
    input wire logic compare_irq_req,
    input wire logic capture_source,
    input wire logic capture_route_enable,
    input wire logic capture_irq_allowed
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic cs_wr = reg_wr && reg_addr == ACC_CTRL_STATUS_OFF;
    wire logic pin_rd = reg_rd && reg_addr == ACC_PIN_DISABLE_OFF;
    a_req_global: assert property (compare_irq_req |-> $past(global_irq_enable))
        else $error("irq request without global enable");
    // register stage then output stage: the written value shows two edges later
    a_power_write: assert property (cs_wr |-> ##2
        analog_ctrl.power_off == $past(reg_wdata[7], 2))
        else $error("power off bit not taken");
    a_bandgap_write: assert property (cs_wr |-> ##2
        analog_ctrl.bandgap_sel == $past(reg_wdata[6], 2))
        else $error("bandgap select not taken");
    a_mux_gated: assert property (analog_ctrl.neg_from_mux |-> !$past(converter_power_reduce))
        else $error("mux used under power reduce");
    a_capture_off: assert property ((!capture_route_enable)[*3] |-> !capture_source)
        else $error("capture source while unrouted");
    a_cap_irq: assert property (capture_irq_allowed |-> $past(timer_capture_irq_enable))
        else $error("capture irq without timer enable");
    a_pin_forced: assert property (pos_pin_buffer_off && $past(pos_pin_buffer_off)
        |-> !positive_pin_read)
        else $error("pin read not forced low");
    a_unused_zero: assert property ($past(pin_rd) |-> reg_rdata[7:2] == 6'h00)
        else $error("unused pin disable bits set");
    c_req: cover property (compare_irq_req);
    c_cap: cover property (capture_source);
    c_wr: cover property (cs_wr);
endmodule
bind acc_analog_comparator_control acc_monitor u_mon (.sys_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .analog_ctrl, .converter_power_reduce,
    .global_irq_enable, .timer_capture_irq_enable, .pos_pin_buffer_off, .positive_pin_read,
    .compare_irq_req, .capture_source, .capture_route_enable, .capture_irq_allowed);

// >>> verification/acc_front_model.sv
`timescale 1ns/10ps
module acc_front_model
    import acc_pkg::*;
(
    input wire acc_analog_ctrl_s ctl,
    input wire logic [7:0] pin_p,
    input wire logic [7:0] pin_n,
    input wire logic [7:0] bgap,
    input wire logic [63:0] chans,
    output logic raw
);
    wire logic [7:0] vp = ctl.bandgap_sel ? bgap : pin_p;
    wire logic [7:0] vn = ctl.neg_from_mux ? chans[ctl.channel*8 +: 8] : pin_n;
    assign raw = !ctl.power_off && vp > vn;
endmodule

// >>> verification/test_analog_comparator_control.sv
`timescale 1ns/10ps
module test_analog_comparator_control
    import acc_pkg::*;
;
    logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, vector_ack = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_q, pin_p = 8'h00;
    logic [7:0] pin_n = 8'h80, bgap = 8'h40;
    logic [63:0] chans = 64'h0000_0010_0000_0000;
    logic positive_pin_digital = 1'h1, negative_pin_digital = 1'h1, global_irq_enable = 1'h1;
    logic converter_power_reduce = 1'h0, timer_capture_irq_enable = 1'h1;
    wire logic [7:0] reg_rdata;
    wire acc_analog_ctrl_s analog_ctrl;
    wire logic compare_raw, pos_pin_buffer_off, neg_pin_buffer_off, positive_pin_read;
    wire logic negative_pin_read, compare_irq_req, capture_source, capture_route_enable;
    wire logic capture_irq_allowed, event_irq;
    int fails = 0, cmp_count = 0;
    acc_analog_comparator_control u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .compare_raw, .analog_ctrl, .positive_pin_digital,
        .negative_pin_digital, .pos_pin_buffer_off, .neg_pin_buffer_off, .positive_pin_read,
        .negative_pin_read, .global_irq_enable, .vector_ack, .converter_power_reduce,
        .timer_capture_irq_enable, .compare_irq_req, .capture_source, .capture_route_enable,
        .capture_irq_allowed, .event_irq);
    acc_front_model u_fe (.ctl(analog_ctrl), .pin_p, .pin_n, .bgap, .chans, .raw(compare_raw));
    always #20 sys_clk = ~sys_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    // settle the synchroniser first, then one read cycle
    task rc(input logic [7:0] a, input logic [7:0] e);
        repeat (4) @(posedge sys_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk) rd_q = reg_rdata;
        chk(rd_q, e);
    endtask
    task t_inputs;
        rc(ACC_CTRL_STATUS_OFF, 8'h00);
        rc(8'h60, 8'h00);
        pin_p <= 8'hc0;
        rc(ACC_CTRL_STATUS_OFF, 8'h30);
        wr(ACC_CTRL_STATUS_OFF, 8'h50);
        rc(ACC_CTRL_STATUS_OFF, 8'h50);
        wr(ACC_CTRL_STATUS_OFF, 8'h50);
        wr(ACC_CONV_CTRL_B_OFF, 8'h40);
        wr(ACC_MUX_SELECT_OFF, 8'h05);
        rc(ACC_CTRL_STATUS_OFF, 8'h70);
        wr(ACC_CONV_CTRL_A_OFF, 8'h80);
        rc(ACC_CTRL_STATUS_OFF, 8'h50);
        wr(ACC_CONV_CTRL_A_OFF, 8'h00);
        converter_power_reduce <= 1'h1;
        rc(ACC_CTRL_STATUS_OFF, 8'h50);
        wr(ACC_CONV_CTRL_B_OFF, 8'h00);
        converter_power_reduce <= 1'h0;
    endtask
    task t_modes;
        logic f;
        for (logic [7:0] m = 8'h00; m < 8'h04; m++) begin
            pin_p <= 8'h00;
            wr(ACC_CTRL_STATUS_OFF, m);
            repeat (4) @(posedge sys_clk);
            wr(ACC_CTRL_STATUS_OFF, 8'h18 | m);
            pin_p <= 8'hc0;
            f = m == 8'h00 || m == 8'h03;
            rc(ACC_CTRL_STATUS_OFF, 8'h28 | m | {3'h0, f, 4'h0});
            chk({7'h00, compare_irq_req}, {7'h00, f});
            vector_ack <= 1'h1;
            @(posedge sys_clk);
            vector_ack <= 1'h0;
            rc(ACC_CTRL_STATUS_OFF, 8'h28 | m);
            pin_p <= 8'h00;
            f = m == 8'h00 || m == 8'h02;
            rc(ACC_CTRL_STATUS_OFF, 8'h08 | m | {3'h0, f, 4'h0});
            wr(ACC_CTRL_STATUS_OFF, 8'h08 | m);
            rc(ACC_CTRL_STATUS_OFF, 8'h08 | m | {3'h0, f, 4'h0});
        end
        wr(ACC_CTRL_STATUS_OFF, 8'h10);
    endtask
    task t_events;
        wr(ACC_IRQ_MASK_OFF, 8'h02);
        // earlier scenarios left both sticky events set; this read clears them
        rc(ACC_IRQ_STATUS_OFF, 8'h03);
        rc(ACC_IRQ_STATUS_OFF, 8'h00);
        pin_p <= 8'hc0;
        rc(ACC_IRQ_MASK_OFF, 8'h02);
        chk({7'h00, event_irq}, 8'h01);
        rc(ACC_IRQ_STATUS_OFF, 8'h03);
        chk({7'h00, event_irq}, 8'h00);
        wr(ACC_IRQ_MASK_OFF, 8'h00);
        pin_p <= 8'h00;
        rc(ACC_IRQ_STATUS_OFF, 8'h03);
        chk({7'h00, event_irq}, 8'h00);
    endtask
    task t_pins_capture;
        wr(ACC_PIN_DISABLE_OFF, 8'hff);
        rc(ACC_PIN_DISABLE_OFF, 8'h03);
        chk({4'h0, pos_pin_buffer_off, neg_pin_buffer_off, positive_pin_read,
            negative_pin_read}, 8'h0c);
        wr(ACC_PIN_DISABLE_OFF, 8'h00);
        rc(ACC_PIN_DISABLE_OFF, 8'h00);
        chk({6'h00, positive_pin_read, negative_pin_read}, 8'h03);
        pin_p <= 8'hc0;
        // the rise lands after the flag clear, so toggle mode sets the flag again
        wr(ACC_CTRL_STATUS_OFF, 8'h14);
        rc(ACC_CTRL_STATUS_OFF, 8'h34);
        chk({5'h00, capture_route_enable, capture_irq_allowed, capture_source}, 8'h07);
        timer_capture_irq_enable <= 1'h0;
        rc(ACC_CTRL_STATUS_OFF, 8'h34);
        chk({5'h00, capture_route_enable, capture_irq_allowed, capture_source}, 8'h05);
        wr(ACC_CTRL_STATUS_OFF, 8'h80);
        rc(ACC_CTRL_STATUS_OFF, 8'h90);
        chk({6'h00, capture_route_enable, capture_source}, 8'h00);
    endtask
    task stop_test;
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        t_inputs;
        t_modes;
        t_events;
        t_pins_capture;
        stop_test;
    end
    initial begin
        #200000;
        fails++;
        stop_test;
    end
endmodule
